// file: verilog/mod_pkg.sv
// Purpose: shared constants for the opcode decoder and flag update logic
// Assumes: 8-bit opcodes, five-bit condition code register
// Notes: operation codes are internal to the decoder
package mod_pkg;
    // condition code width, bit positions and reset value
    localparam int MOD_COND_W = 5;
    localparam int MOD_COND_H = 4;
    localparam int MOD_COND_I = 3;
    localparam int MOD_COND_N = 2;
    localparam int MOD_COND_Z = 1;
    localparam int MOD_COND_C = 0;
    localparam logic [4:0] MOD_COND_RST = 5'h08;

    // high nibble columns
    localparam logic [3:0] MOD_COL_BRBIT = 4'h0;
    localparam logic [3:0] MOD_COL_BSC = 4'h1;
    localparam logic [3:0] MOD_COL_REL = 4'h2;
    localparam logic [3:0] MOD_COL_RMW_DIR = 4'h3;
    localparam logic [3:0] MOD_COL_RMW_IX0 = 4'h7;
    localparam logic [3:0] MOD_COL_CTL8 = 4'h8;
    localparam logic [3:0] MOD_COL_CTL9 = 4'h9;
    localparam logic [3:0] MOD_COL_IMM = 4'hA;

    // fixed opcodes
    localparam logic [7:0] MOD_OPC_IRET = 8'h80;
    localparam logic [7:0] MOD_OPC_SRET = 8'h81;
    localparam logic [7:0] MOD_OPC_SWINT = 8'h83;
    localparam logic [7:0] MOD_OPC_BSUB = 8'hAD;
    localparam logic [7:0] MOD_OPC_XFER_AX = 8'h97;
    localparam logic [7:0] MOD_OPC_CLEAR_C = 8'h98;
    localparam logic [7:0] MOD_OPC_SET_C = 8'h99;
    localparam logic [7:0] MOD_OPC_CLEAR_I = 8'h9A;
    localparam logic [7:0] MOD_OPC_SET_I = 8'h9B;
    localparam logic [7:0] MOD_OPC_RST_SP = 8'h9C;
    localparam logic [7:0] MOD_OPC_NOOP = 8'h9D;
    localparam logic [7:0] MOD_OPC_XFER_XA = 8'h9F;

    // cycle overrides and adjustments
    localparam logic [3:0] MOD_CYC_IRET = 4'h9;
    localparam logic [3:0] MOD_CYC_SRET = 4'h6;
    localparam logic [3:0] MOD_CYC_SWINT = 4'hB;
    localparam logic [3:0] MOD_CYC_BSUB = 4'h8;
    localparam logic [3:0] MOD_CYC_STORE_ADD = 4'h1;
    localparam logic [3:0] MOD_CYC_JUMP_SUB = 4'h1;
    localparam logic [3:0] MOD_CYC_SUBJ_ADD = 4'h3;

    // register/memory rows
    localparam logic [3:0] MOD_RM_SUB = 4'h0;
    localparam logic [3:0] MOD_RM_COMPARE = 4'h1;
    localparam logic [3:0] MOD_RM_SUB_BORROW = 4'h2;
    localparam logic [3:0] MOD_RM_IDX_COMPARE = 4'h3;
    localparam logic [3:0] MOD_RM_AND = 4'h4;
    localparam logic [3:0] MOD_RM_BIT = 4'h5;
    localparam logic [3:0] MOD_RM_LOAD_ACC = 4'h6;
    localparam logic [3:0] MOD_RM_STORE_ACC = 4'h7;
    localparam logic [3:0] MOD_RM_XOR = 4'h8;
    localparam logic [3:0] MOD_RM_ADC = 4'h9;
    localparam logic [3:0] MOD_RM_OR = 4'hA;
    localparam logic [3:0] MOD_RM_ADD = 4'hB;
    localparam logic [3:0] MOD_RM_JUMP = 4'hC;
    localparam logic [3:0] MOD_RM_SUB_JUMP = 4'hD;
    localparam logic [3:0] MOD_RM_LOAD_IDX = 4'hE;
    localparam logic [3:0] MOD_RM_STORE_IDX = 4'hF;

    // read-modify-write rows
    localparam logic [3:0] MOD_RMW_NEGATE = 4'h0;
    localparam logic [3:0] MOD_RMW_INVERT = 4'h3;
    localparam logic [3:0] MOD_RMW_SHR_LOGIC = 4'h4;
    localparam logic [3:0] MOD_RMW_ROT_RIGHT = 4'h6;
    localparam logic [3:0] MOD_RMW_SHR_ARITH = 4'h7;
    localparam logic [3:0] MOD_RMW_SHL = 4'h8;
    localparam logic [3:0] MOD_RMW_ROT_LEFT = 4'h9;
    localparam logic [3:0] MOD_RMW_DECR = 4'hA;
    localparam logic [3:0] MOD_RMW_INC = 4'hC;
    localparam logic [3:0] MOD_RMW_TEST = 4'hD;
    localparam logic [3:0] MOD_RMW_CLEAR = 4'hF;

    // operation classes
    typedef enum logic [4:0] {
        MOD_OP_NONE = 5'h00, MOD_OP_BRBIT_SET = 5'h01, MOD_OP_BRBIT_CLR = 5'h02,
        MOD_OP_BIT_SET = 5'h03, MOD_OP_BIT_CLEAR = 5'h04, MOD_OP_BRANCH = 5'h05,
        MOD_OP_RMW = 5'h06, MOD_OP_CONTROL = 5'h07, MOD_OP_REGMEM = 5'h08
    } mod_op_t;

    typedef enum logic [1:0] {
        MOD_ST_IDLE = 2'b01,
        MOD_ST_DONE = 2'b10
    } mod_state_t;
endpackage : mod_pkg

// file: verilog/mod_col_table.sv
// Purpose: column lookup of instruction length and base cycle count
// Assumes: high nibble of the opcode selects the column
// Notes: column 8 has no common count, every defined entry there (80, 81, 83) is overridden
`timescale 1ns/1ps
`default_nettype none
module mod_col_table (
    // opcode column
    input wire logic [3:0] i_col,
    // length and cycles
    output logic [1:0] o_len,
    output logic [3:0] o_cyc
);
    always_comb begin
        case (i_col)
            4'h0: begin o_len = 2'h3; o_cyc = 4'hA; end
            4'h1: begin o_len = 2'h2; o_cyc = 4'h7; end
            4'h2: begin o_len = 2'h2; o_cyc = 4'h4; end
            4'h3: begin o_len = 2'h2; o_cyc = 4'h6; end
            4'h4: begin o_len = 2'h1; o_cyc = 4'h4; end
            4'h5: begin o_len = 2'h1; o_cyc = 4'h4; end
            4'h6: begin o_len = 2'h2; o_cyc = 4'h7; end
            4'h7: begin o_len = 2'h1; o_cyc = 4'h6; end
            4'h8: begin o_len = 2'h1; o_cyc = 4'h0; end
            4'h9: begin o_len = 2'h1; o_cyc = 4'h2; end
            4'hA: begin o_len = 2'h2; o_cyc = 4'h2; end
            4'hB: begin o_len = 2'h2; o_cyc = 4'h4; end
            4'hC: begin o_len = 2'h3; o_cyc = 4'h5; end
            4'hD: begin o_len = 2'h3; o_cyc = 4'h6; end
            4'hE: begin o_len = 2'h2; o_cyc = 4'h5; end
            default: begin o_len = 2'h1; o_cyc = 4'h4; end
        endcase
    end
endmodule : mod_col_table
`default_nettype wire

// file: verilog/mod_opcode_decoder.sv
// Purpose: opcode decoder and condition code update for an 8-bit core
// Assumes: one opcode per i_op_valid pulse, with its operands and ALU result beside it
// Notes: outputs are registered, one cycle after the request
// Contract
// - tested flags follow their condition; untouched flags keep their value
// - half carry from adder bit 3 carry, only add and add-with-carry
// - interrupt return reloads whole condition code register from stack
// - only listed opcodes are valid; others flagged undefined
// - length and base cycles come from the high nibble column
// - interrupt return 9, subroutine return 6, software interrupt 11, branch-subroutine 8
// - stores plus one, unconditional jump minus one, subroutine jump plus three
// - columns 0 and 1: even row set, odd row clear, bit is row/2
// - columns A-F register/memory modes and sixteen operations in order
// - columns 3-7 read-modify-write, eleven defined rows
// - bit test branches copy the tested bit into carry
`timescale 1ns/1ps
`default_nettype none
module mod_opcode_decoder
    import mod_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // instruction in
    input wire logic i_op_valid,
    input wire logic [7:0] i_opcode,
    // execution results feeding the flags
    input wire logic [7:0] i_result,
    input wire logic i_carry_out,
    input wire logic i_half_carry,
    input wire logic i_tested_bit,
    input wire logic [4:0] i_stacked_cond,
    // decode out
    output logic o_dec_valid,
    output logic o_undefined,
    output logic [4:0] o_op_class,
    output logic [3:0] o_mode_col,
    output logic [3:0] o_op_row,
    output logic [2:0] o_bit_num,
    output logic [1:0] o_length,
    output logic [3:0] o_cycles,
    // flags
    output logic [4:0] o_cond_code
);
    wire logic [3:0] col = i_opcode[7:4];
    wire logic [3:0] row = i_opcode[3:0];
    wire logic [1:0] col_len;
    wire logic [3:0] col_cyc;

    mod_col_table u_col (
        .i_col(col),
        .o_len(col_len),
        .o_cyc(col_cyc)
    );

    // opcode groups
    wire logic is_brbit = (col == MOD_COL_BRBIT);
    wire logic is_bsc = (col == MOD_COL_BSC);
    wire logic is_branch = (col == MOD_COL_REL);
    wire logic is_rmw = (col >= MOD_COL_RMW_DIR) && (col <= MOD_COL_RMW_IX0);
    wire logic is_regmem = (col >= MOD_COL_IMM);
    wire logic is_ctl = (col == MOD_COL_CTL8) || (col == MOD_COL_CTL9) || (i_opcode == MOD_OPC_BSUB);

    wire logic rmw_row_ok = (row == MOD_RMW_NEGATE) || (row == MOD_RMW_INVERT) || (row == MOD_RMW_SHR_LOGIC)
        || (row == MOD_RMW_ROT_RIGHT) || (row == MOD_RMW_SHR_ARITH) || (row == MOD_RMW_SHL)
        || (row == MOD_RMW_ROT_LEFT) || (row == MOD_RMW_DECR) || (row == MOD_RMW_INC)
        || (row == MOD_RMW_TEST) || (row == MOD_RMW_CLEAR);
    wire logic ctl_ok = (i_opcode == MOD_OPC_IRET) || (i_opcode == MOD_OPC_SRET)
        || (i_opcode == MOD_OPC_SWINT) || (i_opcode == MOD_OPC_BSUB)
        || (i_opcode == MOD_OPC_XFER_AX) || (i_opcode == MOD_OPC_CLEAR_C)
        || (i_opcode == MOD_OPC_SET_C) || (i_opcode == MOD_OPC_CLEAR_I)
        || (i_opcode == MOD_OPC_SET_I) || (i_opcode == MOD_OPC_RST_SP)
        || (i_opcode == MOD_OPC_NOOP) || (i_opcode == MOD_OPC_XFER_XA);
    // immediate column has no store or jump forms
    wire logic imm_bad = (col == MOD_COL_IMM) && ((row == MOD_RM_STORE_ACC) || (row == MOD_RM_JUMP)
        || (row == MOD_RM_SUB_JUMP) || (row == MOD_RM_STORE_IDX));
    wire logic defined = is_brbit || is_bsc || is_branch || (is_rmw && rmw_row_ok) || ctl_ok
        || (is_regmem && !imm_bad);

    wire mod_op_t op_class = !defined ? MOD_OP_NONE :
        is_brbit ? (row[0] ? MOD_OP_BRBIT_CLR : MOD_OP_BRBIT_SET) :
        is_bsc ? (row[0] ? MOD_OP_BIT_CLEAR : MOD_OP_BIT_SET) :
        is_branch ? MOD_OP_BRANCH :
        is_rmw ? MOD_OP_RMW :
        is_ctl ? MOD_OP_CONTROL : MOD_OP_REGMEM;
    wire logic [2:0] bit_num = row[3:1];

    // cycle overrides and register/memory adjustments
    wire logic rm_store = is_regmem && ((row == MOD_RM_STORE_ACC) || (row == MOD_RM_STORE_IDX));
    wire logic rm_jump = is_regmem && (row == MOD_RM_JUMP);
    wire logic rm_subjump = is_regmem && !is_ctl && (row == MOD_RM_SUB_JUMP);
    wire logic [3:0] cycles =
        (i_opcode == MOD_OPC_IRET) ? MOD_CYC_IRET :
        (i_opcode == MOD_OPC_SRET) ? MOD_CYC_SRET :
        (i_opcode == MOD_OPC_SWINT) ? MOD_CYC_SWINT :
        (i_opcode == MOD_OPC_BSUB) ? MOD_CYC_BSUB :
        rm_store ? col_cyc + MOD_CYC_STORE_ADD :
        rm_jump ? col_cyc - MOD_CYC_JUMP_SUB :
        rm_subjump ? col_cyc + MOD_CYC_SUBJ_ADD : col_cyc;

    // flag conditions
    wire logic res_n = i_result[7];
    wire logic res_z = (i_result == 8'h00);
    logic upd_h, upd_n, upd_z, upd_c;
    logic val_n, val_z, val_c;
    always_comb begin
        upd_h = 1'b0;
        upd_n = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        val_n = res_n;
        val_z = res_z;
        val_c = i_carry_out;
        if (op_class == MOD_OP_BRBIT_SET || op_class == MOD_OP_BRBIT_CLR) begin
            upd_c = 1'b1;
            val_c = i_tested_bit;
        end else if (op_class == MOD_OP_RMW) begin
            upd_n = 1'b1;
            upd_z = 1'b1;
            upd_c = !((row == MOD_RMW_DECR) || (row == MOD_RMW_INC) || (row == MOD_RMW_TEST));
            if (row == MOD_RMW_SHR_LOGIC) begin
                val_n = 1'b0;
            end
            if (row == MOD_RMW_INVERT) begin
                val_c = 1'b1;
            end
            if (row == MOD_RMW_CLEAR) begin
                val_n = 1'b0;
                val_z = 1'b1;
                upd_c = 1'b0;
            end
        end else if (op_class == MOD_OP_REGMEM) begin
            upd_n = !(rm_jump || rm_subjump);
            upd_z = !(rm_jump || rm_subjump);
            upd_c = (row == MOD_RM_SUB) || (row == MOD_RM_COMPARE) || (row == MOD_RM_SUB_BORROW)
                || (row == MOD_RM_IDX_COMPARE) || (row == MOD_RM_ADC) || (row == MOD_RM_ADD);
            upd_h = (row == MOD_RM_ADC) || (row == MOD_RM_ADD);
        end else if (op_class == MOD_OP_CONTROL) begin
            upd_c = (i_opcode == MOD_OPC_CLEAR_C) || (i_opcode == MOD_OPC_SET_C);
            val_c = (i_opcode == MOD_OPC_SET_C);
        end
    end

    logic [4:0] cond_calc;
    always_comb begin
        cond_calc = o_cond_code;
        if (upd_h) begin
            cond_calc[MOD_COND_H] = i_half_carry;
        end
        if (upd_n) begin
            cond_calc[MOD_COND_N] = val_n;
        end
        if (upd_z) begin
            cond_calc[MOD_COND_Z] = val_z;
        end
        if (upd_c) begin
            cond_calc[MOD_COND_C] = val_c;
        end
        if (i_opcode == MOD_OPC_CLEAR_I) begin
            cond_calc[MOD_COND_I] = 1'b0;
        end
        if ((i_opcode == MOD_OPC_SET_I) || (i_opcode == MOD_OPC_SWINT)) begin
            cond_calc[MOD_COND_I] = 1'b1;
        end
        if (i_opcode == MOD_OPC_IRET) begin
            cond_calc = i_stacked_cond;
        end
    end

    // undefined opcodes leave flags alone; software must not rely on them
    wire logic [4:0] cond_d = (i_op_valid && defined) ? cond_calc : o_cond_code;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_cond_code <= MOD_COND_RST;
            o_dec_valid <= 1'b0;
            o_undefined <= 1'b0;
            o_op_class <= MOD_OP_NONE;
            o_mode_col <= 4'h0;
            o_op_row <= 4'h0;
            o_bit_num <= 3'h0;
            o_length <= 2'h0;
            o_cycles <= 4'h0;
        end else begin
            o_cond_code <= cond_d;
            o_dec_valid <= i_op_valid;
            if (i_op_valid) begin
                o_undefined <= !defined;
                o_op_class <= op_class;
                o_mode_col <= col;
                o_op_row <= row;
                o_bit_num <= bit_num;
                o_length <= col_len;
                o_cycles <= cycles;
            end
        end
    end
endmodule : mod_opcode_decoder
`default_nettype wire

// file: test/mod_prog_mem.sv
// Purpose: program memory model feeding opcode bytes
// Assumes: byte read combinationally while selected
// Notes: deselected output is inverted so a stale byte never looks valid
`timescale 1ns/1ps
`default_nettype none
module mod_prog_mem (
    // fetch
    input wire logic i_sel,
    input wire logic [7:0] i_addr,
    // data
    output logic [7:0] o_byte
);
    // nibble swap is a permutation, so an address sweep reaches every opcode
    wire logic [7:0] rom_byte = {i_addr[3:0], i_addr[7:4]};
    assign o_byte = i_sel ? rom_byte : ~rom_byte;
endmodule : mod_prog_mem
`default_nettype wire

// file: test/mod_dec_assertions.sv
// Purpose: port checks for the opcode decoder
// Assumes: outputs registered one cycle after i_op_valid
// Notes: bound to every decoder instance
`timescale 1ns/1ps
`default_nettype none
module mod_dec_chk (
    // clock and inputs
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_op_valid,
    input wire logic [7:0] i_opcode,
    input wire logic i_half_carry,
    input wire logic i_tested_bit,
    input wire logic [4:0] i_stacked_cond,
    // outputs
    input wire logic o_dec_valid,
    input wire logic o_undefined,
    input wire logic [4:0] o_op_class,
    input wire logic [2:0] o_bit_num,
    input wire logic [1:0] o_length,
    input wire logic [3:0] o_cycles,
    input wire logic [4:0] o_cond_code
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    wire logic add_op = i_opcode[7:4] >= 4'hA && (i_opcode[3:0] == 4'h9 || i_opcode[3:0] == 4'hB);
    a_valid_follows: assert property (i_op_valid |=> o_dec_valid)
        else $error("decode valid missing");
    a_iret_reload: assert property (i_op_valid && i_opcode == 8'h80 |=> o_cond_code == $past(i_stacked_cond))
        else $error("flags not reloaded from stack");
    a_half_hold: assert property (i_op_valid && !add_op && i_opcode != 8'h80 |=> $stable(o_cond_code[4]))
        else $error("half carry changed");
    a_half_track: assert property (i_op_valid && add_op |=> o_cond_code[4] == $past(i_half_carry))
        else $error("half carry not taken");
    a_undef_keep: assert property (i_op_valid ##1 o_undefined |-> $stable(o_cond_code) && o_op_class == 5'h00)
        else $error("undefined opcode touched state");
    a_brbit_carry: assert property (i_op_valid && i_opcode[7:4] == 4'h0
        |=> o_cond_code[0] == $past(i_tested_bit) && o_length == 2'h3 && o_cycles == 4'hA)
        else $error("bit test branch wrong");
    a_bit_number: assert property (i_op_valid && i_opcode[7:5] == 3'h0 |=> o_bit_num == $past(i_opcode[3:1])
        && o_op_class == {3'h0, $past(i_opcode[4]), $past(i_opcode[0])} + 5'h01)
        else $error("bit operation decode wrong");
    a_flags_stand: assert property (!i_op_valid |=> $stable(o_cond_code))
        else $error("flags changed without request");
endmodule : mod_dec_chk
bind mod_opcode_decoder mod_dec_chk u_chk (.i_clk_sys, .i_rst, .i_op_valid, .i_opcode, .i_half_carry,
    .i_tested_bit, .i_stacked_cond, .o_dec_valid, .o_undefined, .o_op_class, .o_bit_num, .o_length, .o_cycles,
    .o_cond_code);
`default_nettype wire

// file: test/mcu_opcode_decoder_test.sv
// Purpose: self-checking bench for the opcode decoder
// Assumes: inputs change on the falling edge
// Notes: opcodes come from the program memory model
`timescale 1ns/1ps
`default_nettype none
module mcu_opcode_decoder_test import mod_pkg::*;;
    logic i_clk_sys = 1'b0, i_rst = 1'b1, i_op_valid = 1'b0, i_carry_out = 1'b0, i_half_carry = 1'b0;
    logic i_tested_bit = 1'b0;
    logic [7:0] i_result = 8'h00, pm_addr = 8'h00;
    logic [4:0] i_stacked_cond = 5'h00, cond_m = MOD_COND_RST;
    logic [31:0] lfsr_q = 32'h457DF39B;
    int mismatches = 0, samples_checked = 0;
    wire logic [7:0] i_opcode;
    wire logic o_dec_valid, o_undefined;
    wire logic [4:0] o_op_class, o_cond_code;
    wire logic [3:0] o_mode_col, o_op_row, o_cycles;
    wire logic [2:0] o_bit_num;
    wire logic [1:0] o_length;
    localparam logic [15:0] RMW_C = 16'h03D1, RM_C = 16'h0A0F;
    logic [1:0] len_tab [16] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
    logic [3:0] cyc_tab [16] = '{4'hA, 4'h7, 4'h4, 4'h6, 4'h4, 4'h4, 4'h7, 4'h6, 4'h0, 4'h2, 4'h2, 4'h4, 4'h5, 4'h6, 4'h5, 4'h4};
    logic [15:0] def_tab [16] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hB7D9, 16'hB7D9, 16'hB7D9, 16'hB7D9, 16'hB7D9,
        16'h000B, 16'hBF80, 16'h6F7F, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    mod_prog_mem pm (.i_sel(i_op_valid), .i_addr(pm_addr), .o_byte(i_opcode));
    mod_opcode_decoder dut (.i_clk_sys, .i_rst, .i_op_valid, .i_opcode, .i_result, .i_carry_out, .i_half_carry,
        .i_tested_bit, .i_stacked_cond, .o_dec_valid, .o_undefined, .o_op_class, .o_mode_col, .o_op_row, .o_bit_num,
        .o_length, .o_cycles, .o_cond_code);
    initial begin
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    function automatic logic [4:0] cls_of(input logic [7:0] op);
        if (!def_tab[op[7:4]][op[3:0]]) return 5'h00;
        if (op[7:5] == 3'h0) return {3'h0, op[4], op[0]} + 5'h01;
        if (op[7:4] == 4'h2) return 5'h05;
        if (op[7:4] <= 4'h7) return 5'h06;
        if (op[7:4] <= 4'h9 || op == 8'hAD) return 5'h07;
        return 5'h08;
    endfunction : cls_of
    function automatic logic [3:0] cyc_of(input logic [7:0] op);
        if (op == 8'h80) return 4'h9;
        if (op == 8'h81) return 4'h6;
        if (op == 8'h83) return 4'hB;
        if (op == 8'hAD) return 4'h8;
        if (op[7:4] < 4'hB) return cyc_tab[op[7:4]];
        if (op[2:0] == 3'h7) return cyc_tab[op[7:4]] + 4'h1;
        if (op[3:0] == 4'hC) return cyc_tab[op[7:4]] - 4'h1;
        if (op[3:0] == 4'hD) return cyc_tab[op[7:4]] + 4'h3;
        return cyc_tab[op[7:4]];
    endfunction : cyc_of
    function automatic logic [4:0] cond_of(input logic [7:0] op, input logic [4:0] c, input logic [7:0] r,
                                         input logic co, input logic hc, input logic tb, input logic [4:0] stk);
        logic [4:0] k;
        k = cls_of(op);
        if (k == 5'h00) return c;
        if (op == MOD_OPC_IRET) return stk;
        if (op[7:4] == 4'h0) c[0] = tb;
        if (op == 8'h98 || op == 8'h99) c[0] = op[0];
        if (op == 8'h9A || op == 8'h9B) c[3] = op[0];
        if (op == 8'h83) c[3] = 1'b1;
        if (k == 5'h06 || (k == 5'h08 && op[3:1] != 3'h6)) begin
            c[2] = r[7];
            c[1] = (r == 8'h00);
        end
        if (k == 5'h06 && RMW_C[op[3:0]]) c[0] = co;
        if (k == 5'h06 && op[3:0] == 4'h3) c[0] = 1'b1;
        if (k == 5'h06 && op[3:0] == 4'h4) c[2] = 1'b0;
        if (k == 5'h06 && op[3:0] == 4'hF) c[2:1] = 2'b01;
        if (k == 5'h08 && RM_C[op[3:0]]) c[0] = co;
        if (k == 5'h08 && (op[3:0] == 4'h9 || op[3:0] == 4'hB)) c[4] = hc;
        return c;
    endfunction : cond_of
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic step(input logic v, input logic [7:0] a);
        logic [7:0] op;
        lfsr_q = lfsr_next(lfsr_q);
        i_op_valid = v;
        pm_addr = a;
        {i_result, i_carry_out, i_half_carry, i_tested_bit, i_stacked_cond} = lfsr_q[15:0];
        // zero results are rare at random, force some so the zero flag sets
        if (lfsr_q[18:16] == 3'h0) i_result = 8'h00;
        @(posedge i_clk_sys);
        op = i_opcode;
        if (v) cond_m = cond_of(op, cond_m, i_result, i_carry_out, i_half_carry, i_tested_bit, i_stacked_cond);
        @(negedge i_clk_sys);
        check("flags", {3'h0, o_cond_code}, {3'h0, cond_m});
        check("valid", {7'h0, o_dec_valid}, {7'h0, v});
        if (v) begin
            check("class", {3'h0, o_op_class}, {3'h0, cls_of(op)});
            check("undefined", {7'h0, o_undefined}, {7'h0, cls_of(op) == 5'h00});
            if (cls_of(op) != 5'h00) begin
                check("length", {6'h0, o_length}, {6'h0, len_tab[op[7:4]]});
                check("cycles", {4'h0, o_cycles}, {4'h0, cyc_of(op)});
                check("mode_row", {o_mode_col, o_op_row}, op);
            end
            if (op[7:5] == 3'h0) check("bit_num", {5'h0, o_bit_num}, {5'h0, op[3:1]});
        end
    endtask : step
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (2) @(negedge i_clk_sys);
        i_rst = 1'b0;
        for (int i = 0; i < 256; i++) step(1'b1, i[7:0]);
        $display("test opcode sweep done");
        for (int i = 0; i < 2000; i++) step(lfsr_q[20:19] != 2'h0, lfsr_q[31:24]);
        $display("test random stream done");
        i_rst = 1'b1;
        #1;
        check("reset_flags", {3'h0, o_cond_code}, {3'h0, MOD_COND_RST});
        check("reset_valid", {7'h0, o_dec_valid}, 8'h00);
        cond_m = MOD_COND_RST;
        repeat (2) @(negedge i_clk_sys);
        i_rst = 1'b0;
        // return from interrupt right after reset, then undefined, then software interrupt
        step(1'b1, 8'h08);
        step(1'b1, 8'h7A);
        step(1'b1, 8'h38);
        $display("test reset and recovery done");
        final_report();
    end
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        mismatches++;
        final_report();
    end
endmodule : mcu_opcode_decoder_test
`default_nettype wire
